// ---- hdl/adcx_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adcx_defs.svh"
module adcx_host #(
  parameter int RESYNC_CYC = `ADCX_RESYNC_CYC
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  // link to device
  adcx_link_if.host LINK
);
  import adcx_pkg::*;

  adcx_hstate_type st_r;
  logic [5:0] ctrl_r;
  logic [5:0] addr_r;
  adcx_word_type wdata_r;
  adcx_word_type rreg_r;
  adcx_sample_type sample_r;
  logic [2:0] irq_st_r;
  logic [2:0] irq_mask_r;
  logic [2:0] ev;
  logic wr;
  logic auto_prev_r;
  logic need_rec_r;
  logic second_r;
  logic fall_r;
  logic ind_prev_r;
  logic [7:0] sync_cnt_r;
  logic req_r;
  logic req_wr_r;
  logic req_dat_r;
  logic [5:0] laddr_r;
  adcx_word_type lwdata_r;
  logic resync_n_r;
  logic ind_fall;
  logic start_rec;

  // offsets listed in the device map; anything else is reserved
  function automatic logic mapped(input logic [5:0] a);
    return (a == `ADCX_OFS_ID) || (a == `ADCX_OFS_STATUS) || (a == `ADCX_OFS_MODE) ||
      (a == `ADCX_OFS_CLOCK) || (a == `ADCX_OFS_GAIN) || (a == `ADCX_OFS_CFG) ||
      (a == `ADCX_OFS_CHSEL) || (a == `ADCX_OFS_OCAL_U) || (a == `ADCX_OFS_OCAL_L) ||
      (a == `ADCX_OFS_GCAL_U) || (a == `ADCX_OFS_GCAL_L) || (a == `ADCX_OFS_SUPPLY) ||
      (a == `ADCX_OFS_CRC);
  endfunction

  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  assign ind_fall = ind_prev_r && !LINK.new_sample_indicator_n;
  assign start_rec = ctrl_r[`ADCX_C_AUTO] && need_rec_r;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      if (PSEL && !PENABLE && !PWRITE) begin
        if (PADDR == `ADCX_H_CTRL) begin
          PRDATA <= {26'h0, ctrl_r};
        end else if (PADDR == `ADCX_H_ADDR) begin
          PRDATA <= {26'h0, addr_r};
        end else if (PADDR == `ADCX_H_WDATA) begin
          PRDATA <= {16'h0, wdata_r};
        end else if (PADDR == `ADCX_H_RDATA) begin
          PRDATA <= {16'h0, rreg_r};
        end else if (PADDR == `ADCX_H_SAMPLE) begin
          PRDATA <= {8'h0, sample_r};
        end else if (PADDR == `ADCX_H_STAT) begin
          PRDATA <= {31'h0, st_r != ADCX_H_IDLE};
        end else if (PADDR == `ADCX_H_IRQ_STAT) begin
          PRDATA <= {29'h0, irq_st_r};
        end else if (PADDR == `ADCX_H_IRQ_MASK) begin
          PRDATA <= {29'h0, irq_mask_r};
        end else begin
          PRDATA <= '0;
        end
      end
    end
  end

  // go bits self-clear once the engine takes them
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_r <= '0;
      addr_r <= '0;
      wdata_r <= '0;
      irq_mask_r <= '0;
    end else begin
      if (wr && PADDR == `ADCX_H_CTRL) begin
        ctrl_r <= PWDATA[5:0];
      end else if (st_r == ADCX_H_IDLE && !start_rec && !second_r) begin
        ctrl_r[3:0] <= 4'h0;
      end
      if (wr && PADDR == `ADCX_H_ADDR) begin
        addr_r <= PWDATA[5:0];
      end
      if (wr && PADDR == `ADCX_H_WDATA) begin
        wdata_r <= PWDATA[15:0];
      end
      if (wr && PADDR == `ADCX_H_IRQ_MASK) begin
        irq_mask_r <= PWDATA[2:0];
      end
    end
  end

  // RULE_08: one read per indication
  assign ev[`ADCX_E_SAMPLE] = st_r == ADCX_H_REQ && LINK.ack && req_dat_r;
  assign ev[`ADCX_E_REG] = st_r == ADCX_H_REQ && LINK.ack && !req_dat_r;
  assign ev[`ADCX_E_MISS] = ind_fall && fall_r;

  // write one to clear, a same-cycle event still sets
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      irq_st_r <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~((wr && PADDR == `ADCX_H_IRQ_STAT) ? PWDATA[2:0] : 3'h0)) | ev;
      IRQ <= |(irq_st_r & irq_mask_r);
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ind_prev_r <= 1'b1;
      auto_prev_r <= 1'b0;
    end else begin
      ind_prev_r <= LINK.new_sample_indicator_n;
      auto_prev_r <= ctrl_r[`ADCX_C_AUTO];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_r <= ADCX_H_IDLE;
      need_rec_r <= 1'b0;
      second_r <= 1'b0;
      fall_r <= 1'b0;
      sync_cnt_r <= '0;
      req_r <= 1'b0;
      req_wr_r <= 1'b0;
      req_dat_r <= 1'b0;
      laddr_r <= '0;
      lwdata_r <= '0;
      resync_n_r <= 1'b1;
      sample_r <= '0;
      rreg_r <= '0;
    end else begin
      // RULE_05: recovery only after auto restarts
      if (ctrl_r[`ADCX_C_AUTO] && !auto_prev_r) begin
        need_rec_r <= 1'b1;
      end
      if (ind_fall && ctrl_r[`ADCX_C_AUTO]) begin
        fall_r <= 1'b1;
      end
      case (st_r)
        ADCX_H_IDLE: begin
          // RULE_04: resync or double read
          if (ctrl_r[`ADCX_C_SYNC] || (start_rec && ctrl_r[`ADCX_C_BYSYNC])) begin
            need_rec_r <= 1'b0;
            fall_r <= 1'b0;
            resync_n_r <= 1'b0;
            sync_cnt_r <= 8'(RESYNC_CYC - 1);
            st_r <= ADCX_H_SYNC;
          end else if (ctrl_r[`ADCX_C_DATA] || start_rec || second_r || fall_r) begin
            // RULE_07: second read follows at once
            second_r <= start_rec;
            need_rec_r <= 1'b0;
            fall_r <= 1'b0;
            req_r <= 1'b1;
            req_wr_r <= 1'b0;
            req_dat_r <= 1'b1;
            st_r <= ADCX_H_REQ;
          end else if (ctrl_r[`ADCX_C_RREG] || (ctrl_r[`ADCX_C_WREG] && mapped(addr_r))) begin
            // RULE_09: unmapped writes dropped
            req_r <= 1'b1;
            req_wr_r <= ctrl_r[`ADCX_C_WREG] && mapped(addr_r);
            req_dat_r <= 1'b0;
            laddr_r <= addr_r;
            lwdata_r <= wdata_r;
            st_r <= ADCX_H_REQ;
          end
        end
        ADCX_H_REQ: begin
          if (LINK.ack) begin
            req_r <= 1'b0;
            if (req_dat_r) begin
              sample_r <= LINK.rdata;
            end else if (!req_wr_r) begin
              rreg_r <= LINK.rdata[15:0];
            end
            st_r <= ADCX_H_IDLE;
          end
        end
        ADCX_H_SYNC: begin
          if (sync_cnt_r == 8'h00) begin
            resync_n_r <= 1'b1;
            fall_r <= 1'b0;
            st_r <= ADCX_H_IDLE;
          end else begin
            sync_cnt_r <= sync_cnt_r - 8'h01;
          end
        end
        default: begin
          st_r <= ADCX_H_IDLE;
        end
      endcase
    end
  end

  assign LINK.req = req_r;
  assign LINK.req_wr = req_wr_r;
  assign LINK.req_dat = req_dat_r;
  assign LINK.addr = laddr_r;
  assign LINK.wdata = lwdata_r;
  assign LINK.resync_n = resync_n_r;
endmodule
`default_nettype wire

// ---- hdl/adcx_defs.svh ----
`ifndef ADCX_DEFS_SVH
`define ADCX_DEFS_SVH
// device register offsets (word index on the link)
`define ADCX_OFS_ID 6'h00
`define ADCX_OFS_STATUS 6'h01
`define ADCX_OFS_MODE 6'h02
`define ADCX_OFS_CLOCK 6'h03
`define ADCX_OFS_GAIN 6'h04
`define ADCX_OFS_CFG 6'h06
`define ADCX_OFS_CHSEL 6'h09
`define ADCX_OFS_OCAL_U 6'h0a
`define ADCX_OFS_OCAL_L 6'h0b
`define ADCX_OFS_GCAL_U 6'h0c
`define ADCX_OFS_GCAL_L 6'h0d
`define ADCX_OFS_SUPPLY 6'h31
`define ADCX_OFS_CRC 6'h3e
// device reset values
`define ADCX_RST_STATUS 16'h0540
`define ADCX_RST_MODE 16'h0510
`define ADCX_RST_CLOCK 16'h010e
`define ADCX_RST_GAIN 16'h0000
`define ADCX_RST_CFG 16'h0600
`define ADCX_RST_CHSEL 16'h0000
`define ADCX_RST_OCAL_U 16'h0000
`define ADCX_RST_OCAL_L 16'h0000
`define ADCX_RST_GCAL_U 16'h8000
`define ADCX_RST_GCAL_L 16'h0000
`define ADCX_RST_SUPPLY 16'h0000
`define ADCX_RST_CRC 16'h0000
// arbitrary value
`define ADCX_ID_UPPER 8'h4b
// field positions
`define ADCX_MODE_STYLE_BIT 0
`define ADCX_CLOCK_EN_BIT 8
`define ADCX_STATUS_FRESH_BIT 0
// timing
`define ADCX_CLK_MHZ 100
`define ADCX_CONV_NS 15625
`define ADCX_CONV_CYC ((`ADCX_CONV_NS * `ADCX_CLK_MHZ) / 1000)
`define ADCX_RESYNC_NS 1000
`define ADCX_RESYNC_CYC ((`ADCX_RESYNC_NS * `ADCX_CLK_MHZ + 999) / 1000)
`define ADCX_PULSE_CYC 4
// host APB register byte offsets
`define ADCX_H_CTRL 8'h00
`define ADCX_H_ADDR 8'h04
`define ADCX_H_WDATA 8'h08
`define ADCX_H_RDATA 8'h0c
`define ADCX_H_SAMPLE 8'h10
`define ADCX_H_STAT 8'h14
`define ADCX_H_IRQ_STAT 8'h18
`define ADCX_H_IRQ_MASK 8'h1c
// host control bits
`define ADCX_C_DATA 0
`define ADCX_C_RREG 1
`define ADCX_C_WREG 2
`define ADCX_C_SYNC 3
`define ADCX_C_AUTO 4
`define ADCX_C_BYSYNC 5
// host event bits
`define ADCX_E_SAMPLE 0
`define ADCX_E_REG 1
`define ADCX_E_MISS 2
`endif

// ---- hdl/adcx_pkg.sv ----
package adcx_pkg;
  typedef enum logic [1:0] {
    ADCX_H_IDLE = 2'b00,
    ADCX_H_REQ = 2'b01,
    ADCX_H_SYNC = 2'b10
  } adcx_hstate_type;
  typedef logic [23:0] adcx_sample_type;
  typedef logic [15:0] adcx_word_type;
endpackage

// ---- hdl/adcx_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface adcx_link_if;
  import adcx_pkg::*;
  logic req;
  logic req_wr;
  logic req_dat;
  logic [5:0] addr;
  adcx_word_type wdata;
  logic ack;
  adcx_sample_type rdata;
  logic new_sample_indicator_n;
  logic resync_n;
  modport dev(input req, req_wr, req_dat, addr, wdata, resync_n,
    output ack, rdata, new_sample_indicator_n);
  modport host(output req, req_wr, req_dat, addr, wdata, resync_n,
    input ack, rdata, new_sample_indicator_n);
endinterface
`default_nettype wire

// ---- hdl/adcx_device.sv ----
// Function
// RULE_01: each read clears fresh flag, buffers update; the code keeps fresh set when a read finds a second result pending
// RULE_02: unread older results may be dropped
// RULE_03: resync pin restarts timing, empties buffers
// RULE_04: host recovers by resync or double read
// RULE_05: no recovery needed when never behind
// RULE_06: level style, narrow high blip after catch-up
// RULE_07: host reads second set right away
// RULE_08: after catch-up, one sample per indication
// RULE_09: host leaves unmapped offsets untouched
// RULE_10: style 0 level low, style 1 pulse
// RULE_11: holding keeps one, second overrun overwrites both
`timescale 1ns/1ps
`default_nettype none
`include "adcx_defs.svh"
module adcx_device #(
  parameter int CONV_CYC = `ADCX_CONV_CYC,
  parameter logic [7:0] ID_LOWER = 8'h5a // arbitrary value
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // link to host
  adcx_link_if.dev LINK,
  // converter side
  input wire adcx_pkg::adcx_sample_type SAMPLE_DATA,
  output logic CONV_TICK,
  output logic FRESH
);
  import adcx_pkg::*;

  localparam int CW = $clog2(CONV_CYC + 1);

  logic [CW-1:0] cnt_r;
  logic new_res;
  logic resync;
  logic do_req;
  logic rd_dat;
  logic conv_en;
  logic style;
  adcx_sample_type out_r;
  adcx_sample_type hold_r;
  adcx_sample_type hold_nxt;
  logic unread_r;
  logic unread_nxt;
  logic pend_r;
  logic pend_nxt;
  logic blip;
  logic skip;
  logic ack_r;
  adcx_sample_type rdata_r;
  logic ind_n_r;
  logic [2:0] pulse_r;
  adcx_word_type regs_q [0:63];

  function automatic adcx_word_type rst_val(input logic [5:0] a);
    if (a == `ADCX_OFS_MODE) begin
      return `ADCX_RST_MODE;
    end else if (a == `ADCX_OFS_CLOCK) begin
      return `ADCX_RST_CLOCK;
    end else if (a == `ADCX_OFS_GAIN) begin
      return `ADCX_RST_GAIN;
    end else if (a == `ADCX_OFS_CFG) begin
      return `ADCX_RST_CFG;
    end else if (a == `ADCX_OFS_CHSEL) begin
      return `ADCX_RST_CHSEL;
    end else if (a == `ADCX_OFS_OCAL_U) begin
      return `ADCX_RST_OCAL_U;
    end else if (a == `ADCX_OFS_OCAL_L) begin
      return `ADCX_RST_OCAL_L;
    end else if (a == `ADCX_OFS_GCAL_U) begin
      return `ADCX_RST_GCAL_U;
    end else if (a == `ADCX_OFS_GCAL_L) begin
      return `ADCX_RST_GCAL_L;
    end else if (a == `ADCX_OFS_SUPPLY) begin
      return `ADCX_RST_SUPPLY;
    end else begin
      return 16'h0000;
    end
  endfunction

  function automatic logic is_rw(input logic [5:0] a);
    return (a == `ADCX_OFS_MODE) || (a == `ADCX_OFS_CLOCK) || (a == `ADCX_OFS_GAIN) ||
      (a == `ADCX_OFS_CFG) || (a == `ADCX_OFS_CHSEL) || (a == `ADCX_OFS_OCAL_U) ||
      (a == `ADCX_OFS_OCAL_L) || (a == `ADCX_OFS_GCAL_U) || (a == `ADCX_OFS_GCAL_L) ||
      (a == `ADCX_OFS_SUPPLY);
  endfunction

  assign resync = !LINK.resync_n;
  assign do_req = LINK.req && !ack_r;
  assign rd_dat = do_req && LINK.req_dat && !LINK.req_wr;
  assign conv_en = regs_q[`ADCX_OFS_CLOCK][`ADCX_CLOCK_EN_BIT];
  assign style = regs_q[`ADCX_OFS_MODE][`ADCX_MODE_STYLE_BIT];
  assign new_res = conv_en && !resync && (cnt_r == CW'(CONV_CYC - 1));

  // RULE_03: restart timing
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cnt_r <= '0;
    end else if (resync || !conv_en || new_res) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // a read in the same cycle as a new result sees the old holding word
  always_comb begin
    hold_nxt = hold_r;
    unread_nxt = unread_r;
    pend_nxt = pend_r;
    // RULE_01: read clears fresh unless a second result is pending
    if (rd_dat) begin
      if (pend_r) begin
        hold_nxt = out_r;
      end
      unread_nxt = pend_r;
      pend_nxt = 1'b0;
    end
    // RULE_11: keep one, overwrite on second
    if (new_res) begin
      if (!unread_nxt || pend_nxt) begin
        hold_nxt = SAMPLE_DATA;
        pend_nxt = 1'b0;
      end else begin
        pend_nxt = 1'b1;
      end
      unread_nxt = 1'b1;
    end
  end

  // RULE_02: older results dropped here
  // RULE_03: buffers emptied
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      out_r <= '0;
      hold_r <= '0;
      unread_r <= 1'b0;
      pend_r <= 1'b0;
    end else if (resync) begin
      out_r <= '0;
      hold_r <= '0;
      unread_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      if (new_res) begin
        out_r <= SAMPLE_DATA;
      end
      hold_r <= hold_nxt;
      unread_r <= unread_nxt;
      pend_r <= pend_nxt;
    end
  end

  // RULE_06: blip after catch-up read
  assign blip = (rd_dat && pend_r) || (new_res && unread_r && !rd_dat);
  // one pulse is swallowed while a single result waits unread
  assign skip = new_res && unread_r && !pend_r && !rd_dat;

  // RULE_10: level or pulse style
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ind_n_r <= 1'b1;
      pulse_r <= '0;
    end else if (resync) begin
      ind_n_r <= 1'b1;
      pulse_r <= '0;
    end else if (!style) begin
      pulse_r <= '0;
      ind_n_r <= blip ? 1'b1 : !unread_nxt;
    end else if (new_res && !skip) begin
      pulse_r <= 3'(`ADCX_PULSE_CYC - 1);
      ind_n_r <= 1'b0;
    end else if (pulse_r != 3'h0) begin
      pulse_r <= pulse_r - 3'h1;
    end else begin
      ind_n_r <= 1'b1;
    end
  end

  // register map, unmapped and read-only offsets ignore writes
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 64; i++) begin
        regs_q[i] <= rst_val(6'(i));
      end
    end else if (do_req && LINK.req_wr && !LINK.req_dat && is_rw(LINK.addr)) begin
      regs_q[LINK.addr] <= LINK.wdata;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= do_req;
      if (rd_dat) begin
        rdata_r <= hold_r;
      end else if (do_req && !LINK.req_wr) begin
        if (LINK.addr == `ADCX_OFS_ID) begin
          rdata_r <= {8'h00, `ADCX_ID_UPPER, ID_LOWER};
        end else if (LINK.addr == `ADCX_OFS_STATUS) begin
          rdata_r <= {8'h00, `ADCX_RST_STATUS | {15'h0000, unread_r}};
        end else if (is_rw(LINK.addr)) begin
          rdata_r <= {8'h00, regs_q[LINK.addr]};
        end else begin
          rdata_r <= '0;
        end
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CONV_TICK <= 1'b0;
      FRESH <= 1'b0;
    end else begin
      CONV_TICK <= new_res;
      FRESH <= unread_nxt && !resync;
    end
  end

  assign LINK.ack = ack_r;
  assign LINK.rdata = rdata_r;
  assign LINK.new_sample_indicator_n = ind_n_r;
endmodule
`default_nettype wire

// ---- tb/adcx_link_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adcx_defs.svh"
module adcx_link_sva (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // request side
  input wire logic req,
  input wire logic req_wr,
  input wire logic req_dat,
  input wire logic [5:0] addr,
  input wire adcx_pkg::adcx_word_type wdata,
  input wire logic resync_n,
  // answer side
  input wire logic ack,
  input wire adcx_pkg::adcx_sample_type rdata,
  input wire logic new_sample_indicator_n
);
  import adcx_pkg::*;
  logic mapped_ofs;
  assign mapped_ofs = addr inside {`ADCX_OFS_ID, `ADCX_OFS_STATUS, `ADCX_OFS_MODE,
    `ADCX_OFS_CLOCK, `ADCX_OFS_GAIN, `ADCX_OFS_CFG, `ADCX_OFS_CHSEL, `ADCX_OFS_OCAL_U,
    `ADCX_OFS_OCAL_L, `ADCX_OFS_GCAL_U, `ADCX_OFS_GCAL_L, `ADCX_OFS_SUPPLY, `ADCX_OFS_CRC};
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_finish;
    ack ##1 (!ack && !req);
  endsequence
  a_link_answer: assert property (s_take |=> s_finish)
    else $error("link answer missing or too long");
  a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
    else $error("answer without request");
  a_req_steady: assert property (s_take |=> req && $stable(addr) && $stable(req_wr))
    else $error("request changed before answer");
  a_req_kind: assert property (s_take |=> $stable(req_dat) && $stable(wdata))
    else $error("request kind changed before answer");
  a_rdata_holds: assert property (!ack |-> $stable(rdata))
    else $error("answer data moved without answer");
  a_resync_width: assert property ($fell(resync_n) |-> (!resync_n)[*3] ##1 resync_n)
    else $error("restart strobe width wrong");
  a_resync_blank: assert property (!resync_n && !$past(resync_n) |-> new_sample_indicator_n)
    else $error("indicator active during restart");
  a_resync_release: assert property ($rose(resync_n) |-> new_sample_indicator_n[*2])
    else $error("indicator active right after restart");
  a_data_read: assert property (req && req_dat |-> !req_wr)
    else $error("data packet request marked as write");
  a_write_mapped: assert property (req && req_wr |-> mapped_ofs)
    else $error("register write to an unmapped offset");
  c_take: cover property (s_take ##1 s_finish);
endmodule
`default_nettype wire

// ---- tb/adc_readout_resync_and_register_map_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adcx_defs.svh"
module adc_readout_resync_and_register_map_tb_top;
  import adcx_pkg::*;
  logic CLOCK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd_val;
  logic PREADY, PSLVERR, IRQ, CONV_TICK, FRESH;
  adcx_sample_type SAMPLE_DATA = 24'h000000, last = 24'h000000, prev = 24'h000000;
  int fails = 0, n_tests = 0, cyc = 0, seed = 98, w, nb = 0;
  logic [1:0] ind_h = 2'b11;
  logic [63:0] q[$];
  logic [63:0] nt;
  // id low byte is arbitrary
  logic [15:0] id = {`ADCX_ID_UPPER, 8'h3c};
  logic [5:0] ofs [12] = '{`ADCX_OFS_ID, `ADCX_OFS_MODE, `ADCX_OFS_CLOCK, `ADCX_OFS_GAIN,
    `ADCX_OFS_CFG, `ADCX_OFS_CHSEL, `ADCX_OFS_OCAL_U, `ADCX_OFS_OCAL_L, `ADCX_OFS_GCAL_U,
    `ADCX_OFS_GCAL_L, `ADCX_OFS_SUPPLY, `ADCX_OFS_CRC};
  logic [15:0] rstv [12] = '{{`ADCX_ID_UPPER, 8'h3c}, `ADCX_RST_MODE, `ADCX_RST_CLOCK,
    `ADCX_RST_GAIN, `ADCX_RST_CFG, `ADCX_RST_CHSEL, `ADCX_RST_OCAL_U, `ADCX_RST_OCAL_L,
    `ADCX_RST_GCAL_U, `ADCX_RST_GCAL_L, `ADCX_RST_SUPPLY, `ADCX_RST_CRC};
  logic [5:0] wofs [3] = '{`ADCX_OFS_OCAL_U, 6'h05, `ADCX_OFS_ID};
  adcx_link_if u_adcx_link_if ();
  adcx_host #(.RESYNC_CYC(3)) u_adcx_host (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .LINK(u_adcx_link_if));
  adcx_device #(.CONV_CYC(60), .ID_LOWER(8'h3c)) u_adcx_device (.CLOCK(CLOCK), .RST(RST),
    .LINK(u_adcx_link_if), .SAMPLE_DATA(SAMPLE_DATA), .CONV_TICK(CONV_TICK), .FRESH(FRESH));
  adcx_link_sva u_adcx_link_sva (.CLOCK(CLOCK), .RST(RST), .req(u_adcx_link_if.req),
    .req_wr(u_adcx_link_if.req_wr), .req_dat(u_adcx_link_if.req_dat),
    .addr(u_adcx_link_if.addr), .wdata(u_adcx_link_if.wdata),
    .resync_n(u_adcx_link_if.resync_n), .ack(u_adcx_link_if.ack),
    .rdata(u_adcx_link_if.rdata),
    .new_sample_indicator_n(u_adcx_link_if.new_sample_indicator_n));
  always #5 CLOCK = ~CLOCK;
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_tests++;
    if ((got & m) !== (exp & m)) begin
      fails++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // a zero mask means no note is taken
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic [31:0] m);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    if (m !== 32'h0) q.push_back({m, e});
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rd_val = PRDATA;
    check({31'h0, PSLVERR}, 32'h0, 32'h1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 32'hffffffff);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0);
  endtask
  task idle;
    do apb(1'b0, `ADCX_H_STAT, 32'h0, 32'h0, 32'h0); while (rd_val[0] !== 1'b0);
  endtask
  task dreg(input logic w, input logic [5:0] o, input logic [15:0] d);
    wr(`ADCX_H_ADDR, {26'h0, o});
    wr(`ADCX_H_WDATA, {16'h0, d});
    wr(`ADCX_H_CTRL, w ? 32'h4 : 32'h2);
    idle;
  endtask
  task sample_read;
    wr(`ADCX_H_CTRL, 32'h1);
    idle;
  endtask
  task ticks(input int n);
    repeat (n) @(posedge CLOCK iff CONV_TICK === 1'b1);
    @(posedge CLOCK);
  endtask
  // restart strobe lasts three cycles plus register stages
  task resync;
    wr(`ADCX_H_CTRL, 32'h8);
    repeat (6) @(posedge CLOCK);
  endtask
  always @(posedge CLOCK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && q.size() > 0) begin
      nt = q.pop_front();
      check(PRDATA, nt[31:0], nt[63:32]);
    end
  end
  // counts one-cycle high blips of the indicator
  always @(posedge CLOCK) begin
    if ({ind_h, u_adcx_link_if.new_sample_indicator_n} === 3'b010) nb++;
    ind_h <= {ind_h[0], u_adcx_link_if.new_sample_indicator_n};
  end
  // converter input changes only after a result was taken
  always @(posedge CLOCK) begin
    if (CONV_TICK === 1'b1) begin
      prev <= last;
      last <= SAMPLE_DATA;
      SAMPLE_DATA <= adcx_sample_type'($random(seed));
    end
  end
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict;
    end
  end
  initial begin
    logic [15:0] d;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      dreg(1'b0, ofs[i], 16'h0);
      rd(`ADCX_H_RDATA, {16'h0, rstv[i]});
    end
    d = 16'($random(seed));
    for (int k = 0; k < 3; k++) begin
      dreg(1'b1, wofs[k], d);
      dreg(1'b0, wofs[k], 16'h0);
      rd(`ADCX_H_RDATA, {16'h0, k == 0 ? d : k == 1 ? 16'h0 : id});
    end
    resync;
    dreg(1'b0, `ADCX_OFS_STATUS, 16'h0);
    rd(`ADCX_H_RDATA, {16'h0, `ADCX_RST_STATUS});
    for (int n = 1; n < 4; n++) begin
      resync;
      ticks(n);
      if (n == 1) check({31'h0, u_adcx_link_if.new_sample_indicator_n}, 32'h0, 32'h1);
      // one edge past the overrun blip, so only the read blip is counted
      @(posedge CLOCK);
      nb = 0;
      sample_read;
      rd(`ADCX_H_SAMPLE, {8'h0, n == 2 ? prev : last});
      if (n == 2) begin
        check({31'h0, FRESH}, 32'h1, 32'h1);
        check(nb, 32'h1, 32'hffffffff);
        sample_read;
        rd(`ADCX_H_SAMPLE, {8'h0, last});
      end
      check({31'h0, FRESH}, 32'h0, 32'h1);
    end
    wr(`ADCX_H_IRQ_MASK, 32'h1);
    repeat (2) @(posedge CLOCK);
    check({31'h0, IRQ}, 32'h1, 32'h1);
    wr(`ADCX_H_IRQ_STAT, 32'h1);
    apb(1'b0, `ADCX_H_IRQ_STAT, 32'h0, 32'h2, 32'h3);
    check({31'h0, IRQ}, 32'h0, 32'h1);
    wr(`ADCX_H_IRQ_MASK, 32'h0);
    dreg(1'b1, `ADCX_OFS_MODE, `ADCX_RST_MODE | 16'h0001);
    resync;
    do @(posedge CLOCK); while (u_adcx_link_if.new_sample_indicator_n !== 1'b0);
    w = 0;
    while (u_adcx_link_if.new_sample_indicator_n === 1'b0) begin
      w++;
      @(posedge CLOCK);
    end
    check(w, `ADCX_PULSE_CYC, 32'hffffffff);
    for (int b = 0; b < 2; b++) begin
      wr(`ADCX_H_CTRL, b == 1 ? 32'h30 : 32'h10);
      ticks(3);
      repeat (30) @(posedge CLOCK);
      rd(`ADCX_H_SAMPLE, {8'h0, last});
      wr(`ADCX_H_CTRL, 32'h0);
    end
    RST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    dreg(1'b0, `ADCX_OFS_MODE, 16'h0);
    rd(`ADCX_H_RDATA, {16'h0, `ADCX_RST_MODE});
    print_verdict;
  end
endmodule
`default_nettype wire
